/* File: design/dim_pkg.sv */
// Shared constants, types and helper functions for the LED dimming mode controller.
// How it works
// - All timers and counters advance on one 10MHz internal tick.
// - Three-bit field picks one of eight boost switching frequencies, 350kHz to 2.4MHz.
// - With disconnect transistor fitted, drive its gate, then wait 500us.
// - Output below 1.22V after the delay disables the device, no boosting.
// - Remaining safety checks must all pass before boost switching starts.
// - Start-up works whatever order supply, PWM input and enable arrive.
// - Register-duty modes ignore the PWM input pin entirely.
// - Low-side switch turns on each cycle start, held at least 100ns.
// - Light load near input voltage skips pulses, switch held off.
// - Full-scale current is linear in its code, 0.196mA per step.
// - Mode 000b: analog amplitude follows measured PWM pin duty.
// - Mode 001b: analog amplitude follows the 14-bit register duty.
// - Mode 010: current chopped at chop rate, duty from pin.
// - Mode 011: current chopped at chop rate, duty from register.
// - Mode 100b: above transfer point, analog amplitude follows pin duty.
// - Mixed mode below transfer point: chop duty is duty over point, amplitude fixed.
// - Mode 101b: mixed behaviour using the register duty value.
// - Amplitude is always further scaled by the 10-bit amplitude scale.
// - Chop frequency comes from its four-bit field, not the pin frequency.
// - Current ramps in 0.049mA steps, 2us to 128us per step.
package dim_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CORE_CLK_MHZ = 250;
	localparam int INT_CLK_MHZ = 10;
	localparam int TICK_DIV = CORE_CLK_MHZ / INT_CLK_MHZ;
	localparam int GATE_DELAY_US = 500;
	localparam int GATE_DELAY_TICKS = GATE_DELAY_US * INT_CLK_MHZ;
	localparam int MIN_ON_NS = 100;
	localparam int MIN_ON_RAW = (MIN_ON_NS * INT_CLK_MHZ + 999) / 1000;
	localparam int MIN_ON_TICKS = (MIN_ON_RAW < 1) ? 1 : MIN_ON_RAW;
	localparam int RAMP_BASE_US = 2;
	localparam int RAMP_BASE_TICKS = RAMP_BASE_US * INT_CLK_MHZ;
	localparam logic [2:0] RAMP_MAX_SEL = 3'h6;
	localparam int CHOP_STEP_TICKS = 49;

	// ------------------------------------------------------------------
	// Scaling and reset values
	// ------------------------------------------------------------------
	localparam int FS_UNITS_PER_CODE_SHIFT = 2;
	localparam logic [14:0] DUTY_FULL = 15'h4000;
	localparam logic [13:0] DUTY_MAX = 14'h3FFF;
	localparam logic [13:0] TP_BASE = 14'h0400;
	localparam logic [9:0] LEVEL_RESET = 10'h000;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_ANALOG_PIN = 3'b000,
		MODE_ANALOG_REG = 3'b001,
		MODE_CHOP_PIN = 3'b010,
		MODE_CHOP_REG = 3'b011,
		MODE_MIX_PIN = 3'b100,
		MODE_MIX_REG = 3'b101
	} mode_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_GATE_WAIT = 3'b001,
		ST_SHORT_CHECK = 3'b010,
		ST_SAFETY_CHECK = 3'b011,
		ST_RUN = 3'b100,
		ST_FAULT = 3'b101
	} start_e;

	typedef struct packed {
		logic [2:0] switching_freq_select;
		logic [7:0] full_scale_current_code;
		logic [2:0] dimming_mode_select;
		logic [9:0] amplitude_scale;
		logic [13:0] register_duty_value;
		logic [3:0] chop_freq_select;
		logic [1:0] transfer_point_select;
		logic [2:0] ramp_step_time_select;
	} cfg_s;

	typedef struct packed {
		logic enable;
		logic vin_ok;
		logic pwm_in;
		logic vout_below_short;
		logic safety_ok;
		logic peak_current_trip;
		logic light_load_skip;
		logic disconnect_fitted;
	} pins_s;

	localparam int PIN_COUNT = 8;

	// Switching period in internal ticks for each frequency code.
	function automatic logic [5:0] sw_period(input logic [2:0] sel);
		int khz;
		case (sel)
			3'h0: khz = 350;
			3'h1: khz = 500;
			3'h2: khz = 650;
			3'h3: khz = 800;
			3'h4: khz = 950;
			3'h5: khz = 1200;
			3'h6: khz = 1800;
			default: khz = 2400;
		endcase
		return 6'((INT_CLK_MHZ * 1000) / khz);
	endfunction : sw_period

	// Chop period in internal ticks for each chop frequency code.
	function automatic logic [9:0] chop_period(input logic [3:0] sel);
		return 10'(CHOP_STEP_TICKS * (16 - int'(sel)));
	endfunction : chop_period

endpackage : dim_pkg

/* File: design/pwm_duty_meter.sv */
// Measures high time and period of the filtered PWM pin and yields a 14-bit duty.
`timescale 1ns/1ps
module pwm_duty_meter #(
	parameter int CNT_W = 16
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic tick,
	input wire logic pin_level,
	output logic [13:0] duty
);

	initial begin
		if (CNT_W < 15) $error("CNT_W too small for the divider");
	end

	logic pin_d;
	logic [CNT_W-1:0] hi_cnt;
	logic [CNT_W-1:0] per_cnt;
	logic [CNT_W-1:0] per_lat;
	logic [CNT_W:0] rem;
	logic [13:0] q;
	logic [3:0] idx;
	logic busy;
	logic clamp;

	// ------------------------------------------------------------------
	// Edge detect and serial division
	// ------------------------------------------------------------------
	wire rise = pin_level && !pin_d;
	wire per_sat = &per_cnt;
	wire start = rise && (per_cnt != '0);
	wire [CNT_W:0] rem_sh = {rem[CNT_W-1:0], 1'b0};
	wire ge = rem_sh >= {1'b0, per_lat};
	wire [CNT_W:0] rem_next = ge ? (rem_sh - {1'b0, per_lat}) : rem_sh;
	wire [13:0] q_next = q | ({13'h0000, ge} << idx);

	// Counters run on the internal tick; a rising edge closes one period.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pin_d <= 1'b0;
			hi_cnt <= '0;
			per_cnt <= '0;
		end else begin
			pin_d <= pin_level;
			if (rise) begin
				hi_cnt <= '0;
				per_cnt <= '0;
			end else if (tick && !per_sat) begin
				per_cnt <= per_cnt + 1'b1;
				hi_cnt <= hi_cnt + CNT_W'(pin_level);
			end
		end
	end

	// Restoring division gives high time times 2^14 over the period.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			per_lat <= '0;
			rem <= '0;
			q <= '0;
			idx <= 4'h0;
			busy <= 1'b0;
			clamp <= 1'b0;
			duty <= 14'h0000;
		end else if (start) begin
			per_lat <= per_cnt;
			rem <= {1'b0, hi_cnt};
			q <= 14'h0000;
			idx <= 4'hD;
			busy <= 1'b1;
			clamp <= hi_cnt >= per_cnt;
		end else if (busy) begin
			rem <= rem_next;
			q <= q_next;
			idx <= idx - 4'h1;
			if (idx == 4'h0) begin
				busy <= 1'b0;
				duty <= clamp ? dim_pkg::DUTY_MAX : q_next;
			end
		end else if (per_sat) begin
			// A pin that stopped toggling reads as fully on or fully off.
			duty <= pin_level ? dim_pkg::DUTY_MAX : 14'h0000;
		end
	end

endmodule : pwm_duty_meter

/* File: design/current_ramp.sv */
// Moves the LED current level one step at a time toward its target.
`timescale 1ns/1ps
module current_ramp #(
	parameter int LEVEL_W = 10
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic tick,
	input wire logic [2:0] step_sel,
	input wire logic [LEVEL_W-1:0] target,
	output logic [LEVEL_W-1:0] level
);

	initial begin
		if (LEVEL_W < 1) $error("LEVEL_W must be positive");
	end

	logic [11:0] step_cnt;

	// Step time doubles per code, the top code repeats the longest step.
	wire [2:0] sel_eff = (step_sel > dim_pkg::RAMP_MAX_SEL) ? dim_pkg::RAMP_MAX_SEL : step_sel;
	wire [11:0] step_ticks = 12'(dim_pkg::RAMP_BASE_TICKS) << sel_eff;
	wire step_due = tick && (step_cnt >= step_ticks - 12'h001);

	// One unit of level is one 0.049mA step.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			step_cnt <= 12'h000;
			level <= LEVEL_W'(dim_pkg::LEVEL_RESET);
		end else if (step_due) begin
			step_cnt <= 12'h000;
			if (level < target) level <= level + 1'b1;
			else if (level > target) level <= level - 1'b1;
		end else if (tick) begin
			step_cnt <= step_cnt + 12'h001;
		end
	end

	property p_ramp_step;
		@(posedge core_clk) disable iff (!nrst)
		(level != $past(level)) |-> ($past(step_due) &&
			((level == $past(level) + 1'b1) || (level == $past(level) - 1'b1)));
	endproperty
	a_ramp_step: assert property (p_ramp_step) else $error("ramp moved off-step");

endmodule : current_ramp

/* File: design/led_dimming_mode_controller.sv */
// Top of the LED dimming mode controller: start-up, boost timing and dimming modes.
`timescale 1ns/1ps
module led_dimming_mode_controller #(
	parameter int GATE_DELAY_TICKS = dim_pkg::GATE_DELAY_TICKS,
	parameter int DUTY_CNT_W = 16
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire dim_pkg::cfg_s cfg,
	input wire dim_pkg::pins_s pins,
	output logic disconnect_gate_drive,
	output logic boost_active,
	output logic startup_fault,
	output logic low_side_switch,
	output logic led_enable,
	output logic [9:0] led_current_level,
	output logic [13:0] measured_duty
);

	initial begin
		if (GATE_DELAY_TICKS < 1 || GATE_DELAY_TICKS > 8191) $error("GATE_DELAY_TICKS out of range");
	end

	// ------------------------------------------------------------------
	// Internal 10MHz tick
	// ------------------------------------------------------------------
	logic [4:0] div_cnt;
	logic tick;

	// Divides the core clock down to the internal timer rate.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt <= 5'h00;
			tick <= 1'b0;
		end else begin
			tick <= (div_cnt == 5'(dim_pkg::TICK_DIV - 1));
			div_cnt <= (div_cnt == 5'(dim_pkg::TICK_DIV - 1)) ? 5'h00 : div_cnt + 5'h01;
		end
	end

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [dim_pkg::PIN_COUNT-1:0] s1;
	logic [dim_pkg::PIN_COUNT-1:0] s2;
	logic [dim_pkg::PIN_COUNT-1:0] s3;
	logic [dim_pkg::PIN_COUNT-1:0] filt;
	dim_pkg::pins_s pf;

	// Three synchroniser flops and a filter flop per pin; the level moves only once the last two agree.
	generate
		for (genvar i = 0; i < dim_pkg::PIN_COUNT; i++) begin : g_sync
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					s1[i] <= 1'b0;
					s2[i] <= 1'b0;
					s3[i] <= 1'b0;
					filt[i] <= 1'b0;
				end else begin
					s1[i] <= pins[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i]) filt[i] <= s3[i];
				end
			end
		end
	endgenerate
	assign pf = filt;

	// ------------------------------------------------------------------
	// Pin duty measurement
	// ------------------------------------------------------------------
	pwm_duty_meter #(
		.CNT_W(DUTY_CNT_W)
	) u_meter (
		.core_clk(core_clk),
		.nrst(nrst),
		.tick(tick),
		.pin_level(pf.pwm_in),
		.duty(measured_duty)
	);

	// ------------------------------------------------------------------
	// Start-up sequence
	// ------------------------------------------------------------------
	dim_pkg::start_e st;
	dim_pkg::start_e next_st;
	logic [12:0] gate_cnt;

	wire powered = pf.enable && pf.vin_ok;
	wire gate_done = (gate_cnt >= 13'(GATE_DELAY_TICKS - 1)) && tick;

	// Waits for supply and enable in any order, then checks and runs.
	always_comb begin
		next_st = st;
		case (st)
			dim_pkg::ST_IDLE: begin
				if (powered) begin
					next_st = pf.disconnect_fitted ? dim_pkg::ST_GATE_WAIT
						: dim_pkg::ST_SHORT_CHECK;
				end
			end
			dim_pkg::ST_GATE_WAIT: begin
				if (gate_done) next_st = dim_pkg::ST_SHORT_CHECK;
			end
			dim_pkg::ST_SHORT_CHECK: begin
				if (tick) begin
					next_st = pf.vout_below_short ? dim_pkg::ST_FAULT
						: dim_pkg::ST_SAFETY_CHECK;
				end
			end
			dim_pkg::ST_SAFETY_CHECK: begin
				if (pf.safety_ok) next_st = dim_pkg::ST_RUN;
			end
			dim_pkg::ST_RUN: next_st = dim_pkg::ST_RUN;
			dim_pkg::ST_FAULT: next_st = dim_pkg::ST_FAULT;
			default: next_st = dim_pkg::ST_IDLE;
		endcase
		if (!powered) next_st = dim_pkg::ST_IDLE;
	end

	// State register and gate-drive delay counter.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st <= dim_pkg::ST_IDLE;
			gate_cnt <= 13'h0000;
		end else begin
			st <= next_st;
			if (st != dim_pkg::ST_GATE_WAIT) gate_cnt <= 13'h0000;
			else if (tick) gate_cnt <= gate_cnt + 13'h0001;
		end
	end

	// Status outputs, registered.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			disconnect_gate_drive <= 1'b0;
			boost_active <= 1'b0;
			startup_fault <= 1'b0;
		end else begin
			disconnect_gate_drive <= pf.disconnect_fitted && (next_st != dim_pkg::ST_IDLE)
				&& (next_st != dim_pkg::ST_FAULT);
			boost_active <= next_st == dim_pkg::ST_RUN;
			startup_fault <= next_st == dim_pkg::ST_FAULT;
		end
	end

	// ------------------------------------------------------------------
	// Boost switching cycle
	// ------------------------------------------------------------------
	logic [5:0] sw_cnt;
	logic [3:0] on_ticks;
	wire [5:0] sw_per = dim_pkg::sw_period(cfg.switching_freq_select);
	wire cycle_end = tick && (sw_cnt >= sw_per - 6'h01);
	wire min_on_done = on_ticks >= 4'(dim_pkg::MIN_ON_TICKS);
	wire last_tick = tick && (sw_cnt == sw_per - 6'h02);

	// Cycle counter on the internal tick.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sw_cnt <= 6'h00;
		end else if (cycle_end) begin
			sw_cnt <= 6'h00;
		end else if (tick) begin
			sw_cnt <= sw_cnt + 6'h01;
		end
	end

	// Switch turns on at each cycle start unless skipping; off on peak trip.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			low_side_switch <= 1'b0;
			on_ticks <= 4'h0;
		end else if (cycle_end) begin
			low_side_switch <= boost_active && !pf.light_load_skip;
			on_ticks <= 4'h0;
		end else if (low_side_switch) begin
			if (tick && !min_on_done) on_ticks <= on_ticks + 4'h1;
			if ((min_on_done && pf.peak_current_trip) || last_tick || !boost_active) begin
				low_side_switch <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Dimming mode decode
	// ------------------------------------------------------------------
	wire [2:0] mode = cfg.dimming_mode_select;
	wire reg_src = mode[0];
	wire mode_analog = mode[2:1] == 2'b00;
	wire mode_chop = mode[2:1] == 2'b01;
	wire mode_mix = mode[2:1] == 2'b10;
	wire mode_res = mode[2:1] == 2'b11;
	wire [13:0] src_duty = reg_src ? cfg.register_duty_value : measured_duty;
	wire [13:0] tp_duty = dim_pkg::TP_BASE << cfg.transfer_point_select;
	wire below_tp = src_duty < tp_duty;
	wire [2:0] tp_shift = 3'h4 - {1'b0, cfg.transfer_point_select};
	wire [14:0] mix_chop = {1'b0, src_duty} << tp_shift;
	logic [13:0] amp_duty;
	logic [14:0] chop_duty;

	// Amplitude fraction and chop duty for each mode.
	always_comb begin
		amp_duty = 14'h0000;
		chop_duty = 15'h0000;
		if (mode_analog) begin
			amp_duty = src_duty;
			chop_duty = dim_pkg::DUTY_FULL;
		end else if (mode_chop) begin
			amp_duty = dim_pkg::DUTY_MAX;
			chop_duty = {1'b0, src_duty};
		end else if (mode_mix && !below_tp) begin
			amp_duty = src_duty;
			chop_duty = dim_pkg::DUTY_FULL;
		end else if (mode_mix) begin
			amp_duty = tp_duty;
			chop_duty = mix_chop;
		end
	end

	// Full scale in 0.049mA units, times duty fraction, times amplitude scale.
	wire [9:0] fs_units = {cfg.full_scale_current_code, 2'b00};
	wire [23:0] prod_duty = fs_units * amp_duty;
	wire [19:0] prod_scale = prod_duty[23:14] * cfg.amplitude_scale;
	wire [9:0] target = mode_res ? 10'h000 : prod_scale[19:10];

	current_ramp #(
		.LEVEL_W(10)
	) u_ramp (
		.core_clk(core_clk),
		.nrst(nrst),
		.tick(tick),
		.step_sel(cfg.ramp_step_time_select),
		.target(target),
		.level(led_current_level)
	);

	// ------------------------------------------------------------------
	// Chop generator
	// ------------------------------------------------------------------
	logic [9:0] chop_cnt;
	wire [9:0] chop_per = dim_pkg::chop_period(cfg.chop_freq_select);
	wire [24:0] chop_pos = {1'b0, chop_cnt, 14'h0000};
	wire [24:0] chop_lim = chop_duty * chop_per;
	wire chop_on = chop_pos < chop_lim;

	// Chop counter free-runs on the tick, independent of the pin.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			chop_cnt <= 10'h000;
			led_enable <= 1'b0;
		end else begin
			if (tick) chop_cnt <= (chop_cnt >= chop_per - 10'h001) ? 10'h000 : chop_cnt + 10'h001;
			led_enable <= boost_active && !mode_res && chop_on;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_tick_rate;
		@(posedge core_clk) disable iff (!nrst)
		tick |-> ##25 tick;
	endproperty
	a_tick_rate: assert property (p_tick_rate) else $error("internal tick not 10MHz");

	property p_gate_delay;
		@(posedge core_clk) disable iff (!nrst)
		(st == dim_pkg::ST_SHORT_CHECK) && ($past(st) == dim_pkg::ST_GATE_WAIT)
			|-> ($past(gate_cnt) >= 13'(GATE_DELAY_TICKS - 1)) && disconnect_gate_drive;
	endproperty
	a_gate_delay: assert property (p_gate_delay) else $error("short check before delay");

	property p_short_fault;
		@(posedge core_clk) disable iff (!nrst)
		(st == dim_pkg::ST_SHORT_CHECK) && tick && pf.vout_below_short && powered
			|=> ##1 startup_fault && !boost_active;
	endproperty
	a_short_fault: assert property (p_short_fault) else $error("short not latched");

	property p_switch_needs_run;
		@(posedge core_clk) disable iff (!nrst)
		$rose(low_side_switch) |-> $past(boost_active) && (st == dim_pkg::ST_RUN);
	endproperty
	a_switch_needs_run: assert property (p_switch_needs_run) else $error("switch before run");

	property p_min_on;
		@(posedge core_clk) disable iff (!nrst)
		$rose(low_side_switch) && boost_active |-> low_side_switch [*8];
	endproperty
	a_min_on: assert property (p_min_on) else $error("switch on-time too short");

	property p_skip;
		@(posedge core_clk) disable iff (!nrst)
		$rose(low_side_switch) |-> $past(cycle_end) && !$past(pf.light_load_skip);
	endproperty
	a_skip: assert property (p_skip) else $error("pulse not skipped");

	property p_reserved_off;
		@(posedge core_clk) disable iff (!nrst)
		mode_res [*2] |-> !led_enable && (target == 10'h000);
	endproperty
	a_reserved_off: assert property (p_reserved_off) else $error("reserved mode lit LEDs");

	property p_reg_ignores_pin;
		@(posedge core_clk) disable iff (!nrst)
		reg_src && !mode_res && $stable(cfg) |-> $stable(target);
	endproperty
	a_reg_ignores_pin: assert property (p_reg_ignores_pin) else $error("pin used in reg mode");

	property p_mix_low;
		@(posedge core_clk) disable iff (!nrst)
		mode_mix && below_tp |-> (amp_duty == tp_duty) && (chop_duty < dim_pkg::DUTY_FULL);
	endproperty
	a_mix_low: assert property (p_mix_low) else $error("mixed low range wrong");

endmodule : led_dimming_mode_controller

/* File: verif/far_side_model.sv */
// Far side of the controller: PWM dimming source and peak current comparator.
`timescale 1ns/1ps
module far_side_model #(
	parameter int PWM_PERIOD = 2000,
	parameter int PWM_HIGH = 625,
	parameter int TRIP_DELAY = 5
) (
	input wire logic core_clk,
	input wire logic pwm_run,
	input wire logic low_side_switch,
	output logic pwm_in = 1'b0,
	output logic peak_current_trip = 1'b0
);
	int pwm_cnt = 0;
	int on_cnt = 0;

	// ------------------------------------------------------------------
	// Dimming source and inductor current
	// ------------------------------------------------------------------
	// A stopped source rests at the pull-down level, never at its last value.
	always @(posedge core_clk) begin
		pwm_cnt <= (pwm_cnt + 1) % PWM_PERIOD;
		pwm_in <= pwm_run && (pwm_cnt < PWM_HIGH);
	end

	// The current trips early so that the switch must hold its minimum on-time.
	always @(posedge core_clk) begin
		on_cnt <= low_side_switch ? on_cnt + 1 : 0;
		peak_current_trip <= low_side_switch && (on_cnt >= TRIP_DELAY);
	end
endmodule : far_side_model

/* File: verif/tb_led_dimming_mode_controller.sv */
// Self-checking bench for the LED dimming mode controller.
`timescale 1ns/1ps
module tb_led_dimming_mode_controller;
	typedef struct {int kind; logic [15:0] exp; int base;} note_s;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	dim_pkg::cfg_s cfg = '0;
	dim_pkg::pins_s pins;
	logic en = 1'b0, vin = 1'b0, shrt = 1'b0, safe = 1'b0, skip = 1'b0, fit = 1'b1;
	logic prun = 1'b0;
	logic pwm_in, trip, gate_drv, boost, fault, ls, le;
	logic [9:0] lvl;
	logic [13:0] duty;
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	int seed = 10;
	int le_cnt = 0, ls_cnt = 0, on_len = 0, min_on = 999, last_per = 0, per_cnt = 0;
	int per[8] = '{700, 500, 375, 300, 250, 200, 125, 100};
	note_s notes[$];
	event check_ev;

	always #2 core_clk = ~core_clk;
	assign pins = {en, vin, pwm_in, shrt, safe, trip, skip, fit};

	led_dimming_mode_controller #(.GATE_DELAY_TICKS(4), .DUTY_CNT_W(16))
	led_dimming_mode_controller_i (.core_clk(core_clk), .nrst(nrst), .cfg(cfg),
		.pins(pins), .disconnect_gate_drive(gate_drv), .boost_active(boost),
		.startup_fault(fault), .low_side_switch(ls), .led_enable(le),
		.led_current_level(lvl), .measured_duty(duty));

	far_side_model far_side_model_i (.core_clk(core_clk), .pwm_run(prun),
		.low_side_switch(ls), .pwm_in(pwm_in), .peak_current_trip(trip));

	// ------------------------------------------------------------------
	// Watching and comparing
	// ------------------------------------------------------------------
	function automatic logic [15:0] observe(input note_s n);
		case (n.kind)
			0: return 16'(boost);
			1: return 16'(fault);
			2: return 16'(gate_drv);
			3: return 16'(lvl);
			4: return 16'(le);
			5: return 16'(duty[13:11]);
			6: return 16'(last_per);
			7: return 16'(ls_cnt != n.base);
			8: return 16'(min_on >= 24);
			default: return 16'(le_cnt != n.base);
		endcase
	endfunction : observe

	// Measures switch periods, on-times and chop edges; cuts a hang short.
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if ($rose(le)) le_cnt <= le_cnt + 1;
		per_cnt <= $rose(ls) ? 1 : per_cnt + 1;
		if ($rose(ls)) ls_cnt <= ls_cnt + 1;
		if ($rose(ls)) last_per <= per_cnt;
		on_len <= ls ? on_len + 1 : 0;
		if ($fell(ls) && on_len < min_on) min_on <= on_len;
		if (cycles == 100000) begin
			$display("Error at %0t: timeout", $time);
			n_fail++;
			stop_test();
		end
	end

	// Takes every note off the queue, oldest first, and compares each with the outputs.
	initial forever begin
		@(check_ev);
		while (notes.size() > 0) begin
			note_s n;
			n = notes.pop_front();
			check_count++;
			if (observe(n) !== n.exp) begin
				n_fail++;
				$display("Error at %0t: kind %0d got %0h want %0h", $time, n.kind,
					observe(n), n.exp);
			end
		end
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic run(input int n);
		repeat (n) @(posedge core_clk);
	endtask : run

	task automatic note(input int kind, input logic [15:0] exp, input int base = 0);
		#1;
		notes.push_back('{kind, exp, base});
		-> check_ev;
		@(posedge core_clk);
	endtask : note

	task automatic settle(input int kind, input logic [15:0] exp, input int lim);
		note_s n;
		n = '{kind, exp, 0};
		for (int i = 0; i < lim && observe(n) !== exp; i++) @(posedge core_clk);
		note(kind, exp);
	endtask : settle

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		int b;
		int md[10] = '{0, 4, 2, 1, 1, 3, 5, 5, 6, 7};
		int dt[10] = '{'h3FFF, 'h3FFF, 'h3FFF, 'h3FFF, 'h3FFF,
			'h2000, 'h0800, 'h3FFF, 'h3FFF, 'h3FFF};
		int am[10] = '{'h100, 'h100, 'h3FF, 'h3FF, 'h200,
			'h3FF, 'h3FF, 'h3FF, 'h3FF, 'h3FF};
		int lv[10] = '{1, 1, 14, 14, 7, 14, 3, 14, 0, 0};
		int ch[10] = '{0, 0, 1, 0, 0, 1, 1, 0, 0, 0};
		int ex[10] = '{1, 1, 0, 1, 1, 0, 0, 1, 0, 0};
		cfg.switching_freq_select = 3'h7;
		cfg.full_scale_current_code = 8'h04;
		cfg.transfer_point_select = 2'h2;
		cfg.chop_freq_select = 4'hF;
		run(8);
		nrst <= 1'b1;
		shrt <= 1'b1;
		safe <= 1'b1;
		b = $random(seed) & 7;
		if (b[0]) vin <= 1'b1;
		else en <= 1'b1;
		run(b + 1);
		vin <= 1'b1;
		en <= 1'b1;
		run(40);
		note(2, 1);
		note(1, 0);
		settle(1, 1, 300);
		note(0, 0);
		en <= 1'b0;
		settle(1, 0, 20);
		$display("Shorted start-up done");
		shrt <= 1'b0;
		safe <= 1'b0;
		fit <= 1'b0;
		run($random(seed) & 15);
		en <= 1'b1;
		run(400);
		note(0, 0);
		note(1, 0);
		note(2, 0);
		safe <= 1'b1;
		settle(0, 1, 20);
		// Supply and enable stand before the dimming source starts.
		prun <= 1'b1;
		b = ls_cnt;
		run(1000);
		note(7, 1, b);
		note(8, 1);
		for (int c = 0; c < 8; c++) begin
			cfg.switching_freq_select <= 3'(c);
			run(1600);
			note(6, 16'(per[c]));
		end
		skip <= 1'b1;
		run(30);
		b = ls_cnt;
		run(800);
		note(7, 0, b);
		skip <= 1'b0;
		note(5, 16'h0002);
		$display("Boost start-up and switching done");
		for (int k = 0; k < 10; k++) begin
			cfg.dimming_mode_select <= 3'(md[k]);
			cfg.register_duty_value <= 14'(dt[k]);
			cfg.amplitude_scale <= 10'(am[k]);
			settle(3, 16'(lv[k]), 9000);
			b = le_cnt;
			run(2600);
			if (ch[k] == 1) note(9, 1, b);
			else note(4, 16'(ex[k]));
		end
		$display("Dimming modes done");
		nrst <= 1'b0;
		run(2);
		note(0, 0);
		note(3, 0);
		stop_test();
	end
endmodule : tb_led_dimming_mode_controller
